// >>> scrr_map.svh
`ifndef SCRR_MAP_SVH
`define SCRR_MAP_SVH

// ----------------------------------------------------------------
// device register addresses (15-bit serial address space)
// ----------------------------------------------------------------
`define SCRR_ADDR_CFG_A 15'h0000
`define SCRR_ADDR_CFG_B 15'h0001
`define SCRR_ADDR_PAIR 15'h0009

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCRR_CFG_A_RST 8'h00
`define SCRR_CFG_B_RST 8'h00
`define SCRR_PAIR_RST 2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCRR_A_SOFT_HI 7
`define SCRR_A_LSB_MIR 6
`define SCRR_A_ASC_MIR 5
`define SCRR_A_ASC 2
`define SCRR_A_LSB 1
`define SCRR_A_SOFT_LO 0
`define SCRR_B_SINGLE 7
`define SCRR_B_DP_RST 1
`define SCRR_SOFT_RESET_CODE 8'h81

// ----------------------------------------------------------------
// frame layout and timing
// ----------------------------------------------------------------
`define SCRR_INSTR_LAST 5'd15
`define SCRR_BYTE_LAST 5'd7
`define SCRR_FRAME_LAST 5'd23
`define SCRR_READ_BIT 15
`define SCRR_BOOT_WAIT_US 5000
`define SCRR_CLK_MHZ 125
`define SCRR_BOOT_WAIT_CYC (`SCRR_BOOT_WAIT_US * `SCRR_CLK_MHZ)

// ----------------------------------------------------------------
// host controller apb offsets and status bits
// ----------------------------------------------------------------
`define SCRR_APB_CTRL 12'h000
`define SCRR_APB_STATUS 12'h004
`define SCRR_APB_RDATA 12'h008
`define SCRR_CTRL_RD 15
`define SCRR_ST_BUSY 0
`define SCRR_ST_BOOT 1
`define SCRR_ST_ERR 2
`define SCRR_ST_LSB 3

`endif

// >>> scrr_pkg.sv
`default_nettype none
package scrr_pkg;

   // device frame phase
   typedef enum logic [1:0] {scrr_ph_instr, scrr_ph_data, scrr_ph_hold} scrr_phase_t;

   // host sequencer state
   typedef enum logic [1:0] {scrr_hs_idle, scrr_hs_shift, scrr_hs_boot} scrr_hstate_t;

   // device state
   typedef struct packed {
      scrr_phase_t phase;
      logic sclk_q;
      logic [4:0] cnt;
      logic [15:0] sh;
      logic rd;
      logic [14:0] addr;
      logic [7:0] tx;
      logic sdo;
      logic sdo_oe_n;
      logic lsb;
      logic asc;
      logic single;
      logic [1:0] pair;
      logic soft_pulse;
      logic dp_pulse;
   } scrr_dev_st_t;

   // host state
   typedef struct packed {
      scrr_hstate_t st;
      logic div;
      logic sclk;
      logic cs_n;
      logic sdo;
      logic oe_n;
      logic [4:0] cnt;
      logic [23:0] frame;
      logic rd;
      logic [14:0] addr;
      logic [7:0] wdat;
      logic [7:0] rx;
      logic [7:0] rdata;
      logic lsb;
      logic err;
      logic [23:0] boot_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } scrr_host_st_t;

endpackage : scrr_pkg
`default_nettype wire

// >>> scrr_if.sv
`default_nettype none
interface scrr_if;
   // serial clock and frame, driven by the host
   logic sclk;
   logic chip_select_n;
   // two-way data pin, split per end
   logic sdio_host_o;
   logic sdio_host_oe_n;
   logic sdio_dev_o;
   logic sdio_dev_oe_n;
   // resolved wire level, pulled up when nobody drives
   logic sdio;

   assign sdio = !sdio_host_oe_n ? sdio_host_o : (!sdio_dev_oe_n ? sdio_dev_o : 1'b1);

   modport dev (input sclk, input chip_select_n, input sdio,
                output sdio_dev_o, output sdio_dev_oe_n);
   modport host (output sclk, output chip_select_n, output sdio_host_o,
                 output sdio_host_oe_n, input sdio);
endinterface : scrr_if
`default_nettype wire

// >>> scrr_dev.sv
`include "scrr_map.svh"
`default_nettype none
module scrr_dev
   import scrr_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // serial port
   scrr_if.dev spi,
   // configuration seen by the rest of the chip
   output logic lsb_first,
   output logic single_instruction,
   output logic [1:0] pair_select,
   // self-clearing reset strobes
   output logic soft_reset_pulse,
   output logic datapath_reset_pulse
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // read decode, used at instruction end and at each streamed byte
   // reserved bits and unmapped addresses fall through and read as zero;
   // the soft reset and datapath reset bits are never stored, so read zero
   function automatic logic [7:0] rd_reg(input logic [14:0] a, input scrr_dev_st_t s);
      logic [7:0] v;
      v = 8'h00;
      if (a == `SCRR_ADDR_CFG_A) begin
         v[`SCRR_A_LSB] = s.lsb;
         v[`SCRR_A_LSB_MIR] = s.lsb;
         v[`SCRR_A_ASC] = s.asc;
         v[`SCRR_A_ASC_MIR] = s.asc;
      end else if (a == `SCRR_ADDR_CFG_B) begin
         v[`SCRR_B_SINGLE] = s.single;
      end else if (a == `SCRR_ADDR_PAIR) begin
         v[1:0] = s.pair;
      end
      return v;
   endfunction : rd_reg

   // first bit on the wire for a byte in the current order
   function automatic logic first_bit(input logic [7:0] b, input logic lsb);
      return lsb ? b[0] : b[7];
   endfunction : first_bit

   // byte after one bit has left the wire
   function automatic logic [7:0] shift_byte(input logic [7:0] b, input logic lsb);
      return lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
   endfunction : shift_byte

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   scrr_dev_st_t s; // registered state
   scrr_dev_st_t next_s; // next state
   logic rise; // sclk rising edge seen this cycle
   logic [15:0] sh_v; // shifter including the bit just sampled
   logic [7:0] byte_v; // completed data byte
   logic [7:0] rd_v; // read data for the next byte
   logic [14:0] addr_inc; // address of the following byte

   // sclk is sampled on pclk and compared with last cycle's copy, so the
   // port reacts one pclk after each rising edge; sclk must stay at each level for
   // at least one pclk cycle or an edge is lost
   assign rise = spi.sclk && !s.sclk_q;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // one process computes the whole next state; only the registered copy
   // drives anything, which keeps every output glitch free
   always_comb begin
      next_s = s;
      next_s.sclk_q = spi.sclk;
      next_s.soft_pulse = 1'b0;
      next_s.dp_pulse = 1'b0;
      // incoming bit enters from the end given by the order
      sh_v = s.lsb ? {spi.sdio, s.sh[15:1]} : {s.sh[14:0], spi.sdio};
      byte_v = s.lsb ? sh_v[15:8] : sh_v[7:0];
      // auto-increment for either ascension setting
      // the ascension bit is kept for readback only; both settings count up,
      // which keeps the stream logic to a single adder
      addr_inc = s.addr + 15'h0001;
      rd_v = rd_reg(addr_inc, s);
      if (spi.chip_select_n) begin
         // frame closed: port restarts at the instruction
         // a cut frame needs no extra care: chip select high restarts
         // the port at the instruction whatever phase it was in
         next_s.phase = scrr_ph_instr;
         next_s.cnt = 5'd0;
         next_s.sdo_oe_n = 1'b1;
      end else if (rise && s.phase != scrr_ph_hold) begin
         next_s.sh = sh_v;
         next_s.cnt = s.cnt + 5'd1;
         if (s.phase == scrr_ph_instr) begin
            if (s.cnt == `SCRR_INSTR_LAST) begin
               // instruction complete
               next_s.rd = sh_v[`SCRR_READ_BIT];
               next_s.addr = sh_v[14:0];
               next_s.phase = scrr_ph_data;
               next_s.cnt = 5'd0;
               if (sh_v[`SCRR_READ_BIT]) begin
                  // turn the pin round before the first data edge
                  // the direction is known only after the last instruction
                  // bit, so the first data bit appears one pclk after that edge
                  next_s.tx = rd_reg(sh_v[14:0], s);
                  next_s.sdo = first_bit(next_s.tx, s.lsb);
                  next_s.sdo_oe_n = 1'b0;
               end
            end
         end else begin
            // data phase: present the next read bit
            if (s.rd) begin
               next_s.tx = shift_byte(s.tx, s.lsb);
               next_s.sdo = first_bit(next_s.tx, s.lsb);
            end
            if (s.cnt == `SCRR_BYTE_LAST) begin
               next_s.cnt = 5'd0;
               next_s.addr = addr_inc;
               if (s.rd) begin
                  // streamed read loads the following register
                  next_s.tx = rd_v;
                  next_s.sdo = first_bit(rd_v, s.lsb);
               end else if (s.addr == `SCRR_ADDR_CFG_A) begin
                  // soft reset on either copy of the field
                  if (byte_v[`SCRR_A_SOFT_HI] || byte_v[`SCRR_A_SOFT_LO]) begin
                     next_s.lsb = 1'(`SCRR_CFG_A_RST >> `SCRR_A_LSB);
                     next_s.asc = 1'(`SCRR_CFG_A_RST >> `SCRR_A_ASC);
                     next_s.single = 1'(`SCRR_CFG_B_RST >> `SCRR_B_SINGLE);
                     next_s.pair = `SCRR_PAIR_RST;
                     next_s.soft_pulse = 1'b1;
                  end else begin
                     // bit order taken from both copies
                     next_s.lsb = byte_v[`SCRR_A_LSB] || byte_v[`SCRR_A_LSB_MIR];
                     next_s.asc = byte_v[`SCRR_A_ASC] || byte_v[`SCRR_A_ASC_MIR];
                  end
               end else if (s.addr == `SCRR_ADDR_CFG_B) begin
                  next_s.single = byte_v[`SCRR_B_SINGLE];
                  next_s.dp_pulse = byte_v[`SCRR_B_DP_RST];
               end else if (s.addr == `SCRR_ADDR_PAIR) begin
                  // pair index is global as well
                  next_s.pair = byte_v[1:0];
               end
               // single mode ignores the rest of the frame
               // soft reset also parks the port until the frame ends
               if (s.single || next_s.soft_pulse) begin
                  next_s.phase = scrr_ph_hold;
                  next_s.sdo_oe_n = 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // the reset branch restores the power-up map: msb first, pair index
   // selecting both pairs, pin released to the pull-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.phase <= scrr_ph_instr;
         s.sdo_oe_n <= 1'b1;
         s.lsb <= 1'b0;
         s.pair <= `SCRR_PAIR_RST;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   // the pulses stand for one pclk; the logic that takes them must run on
   // this clock
   assign spi.sdio_dev_o = s.sdo;
   assign spi.sdio_dev_oe_n = s.sdo_oe_n;
   assign lsb_first = s.lsb;
   assign single_instruction = s.single;
   assign pair_select = s.pair;
   assign soft_reset_pulse = s.soft_pulse;
   assign datapath_reset_pulse = s.dp_pulse;

endmodule : scrr_dev
`default_nettype wire

// >>> scrr_host.sv
`include "scrr_map.svh"
`default_nettype none
module scrr_host
   import scrr_pkg::*;
#(
   // boot loader wait after soft reset, in pclk cycles
   parameter int BOOT_WAIT_CYC = `SCRR_BOOT_WAIT_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial port
   scrr_if.host spi
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // only the supported map may be written
   function automatic logic legal_wr(input logic [14:0] a);
      return a == `SCRR_ADDR_CFG_A || a == `SCRR_ADDR_CFG_B || a == `SCRR_ADDR_PAIR;
   endfunction : legal_wr

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   scrr_host_st_t s; // registered state
   scrr_host_st_t next_s; // next state
   logic acc; // access phase seen
   logic commit; // edge at which the master samples pready
   logic [15:0] instr_v; // instruction word from pwdata
   logic [23:0] fr_v; // frame after one bit left
   logic soft_v; // finished write was a soft reset
   logic clr_err; // software clear of the refusal flag

   assign acc = psel && penable;
   assign commit = acc && s.pready;
   assign instr_v = {pwdata[`SCRR_CTRL_RD], pwdata[14:0]};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      clr_err = 1'b0;
      // one wait state: pready answers the second access cycle
      next_s.pready = acc && !s.pready;
      next_s.pslverr = 1'b0;
      fr_v = s.lsb ? {1'b0, s.frame[23:1]} : {s.frame[22:0], 1'b0};
      soft_v = (s.wdat & `SCRR_SOFT_RESET_CODE) != 8'h00;
      if (acc && !s.pready) begin
         // read data and error are ready with pready
         if (paddr == `SCRR_APB_CTRL) begin
            next_s.prdata = {8'h00, s.wdat, s.rd, s.addr};
         end else if (paddr == `SCRR_APB_STATUS) begin
            next_s.prdata = 32'h0000_0000;
            next_s.prdata[`SCRR_ST_BUSY] = s.st != scrr_hs_idle;
            next_s.prdata[`SCRR_ST_BOOT] = s.st == scrr_hs_boot;
            next_s.prdata[`SCRR_ST_ERR] = s.err;
            next_s.prdata[`SCRR_ST_LSB] = s.lsb;
         end else if (paddr == `SCRR_APB_RDATA) begin
            next_s.prdata = {24'h000000, s.rdata};
         end else begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b1;
         end
      end
      // write commands act at the sampling edge only
      if (commit && pwrite && paddr == `SCRR_APB_STATUS) begin
         clr_err = pwdata[`SCRR_ST_ERR];
      end
      if (clr_err) begin
         next_s.err = 1'b0;
      end
      case (s.st)
         scrr_hs_idle: begin
            if (commit && pwrite && paddr == `SCRR_APB_CTRL) begin
               if (!instr_v[`SCRR_READ_BIT] && !legal_wr(instr_v[14:0])) begin
                  next_s.err = 1'b1;
               end else begin
                  next_s.st = scrr_hs_shift;
                  next_s.rd = instr_v[`SCRR_READ_BIT];
                  next_s.addr = instr_v[14:0];
                  next_s.wdat = pwdata[23:16];
                  // frame oriented for the current bit order
                  next_s.frame = s.lsb ? {pwdata[23:16], instr_v} : {instr_v, pwdata[23:16]};
                  next_s.sdo = s.lsb ? instr_v[0] : instr_v[15];
                  next_s.oe_n = 1'b0;
                  next_s.cs_n = 1'b0;
                  next_s.sclk = 1'b0;
                  next_s.div = 1'b0;
                  next_s.cnt = 5'd0;
               end
            end
         end
         scrr_hs_shift: begin
            // refuse new commands while a frame runs
            if (commit && pwrite && paddr == `SCRR_APB_CTRL) begin
               next_s.err = 1'b1;
            end
            next_s.div = !s.div;
            if (s.div && !s.sclk) begin
               // rising edge: sample read data
               next_s.sclk = 1'b1;
               if (s.rd && s.cnt > `SCRR_INSTR_LAST) begin
                  next_s.rx = s.lsb ? {spi.sdio, s.rx[7:1]} : {s.rx[6:0], spi.sdio};
               end
            end else if (s.div) begin
               // falling edge: next bit or end of frame
               next_s.sclk = 1'b0;
               next_s.cnt = s.cnt + 5'd1;
               next_s.frame = fr_v;
               next_s.sdo = s.lsb ? fr_v[0] : fr_v[23];
               if (s.rd && s.cnt == `SCRR_INSTR_LAST) begin
                  // release the pin to the device
                  next_s.oe_n = 1'b1;
               end
               if (s.cnt == `SCRR_FRAME_LAST) begin
                  next_s.cs_n = 1'b1;
                  next_s.oe_n = 1'b1;
                  next_s.st = scrr_hs_idle;
                  if (s.rd) begin
                     next_s.rdata = s.rx;
                  end else if (s.addr == `SCRR_ADDR_CFG_A) begin
                     if (soft_v) begin
                        // hold off every command for the boot wait
                        next_s.lsb = 1'b0;
                        next_s.st = scrr_hs_boot;
                        next_s.boot_cnt = 24'(BOOT_WAIT_CYC - 1);
                     end else begin
                        // track the device's bit order
                        next_s.lsb = s.wdat[`SCRR_A_LSB] || s.wdat[`SCRR_A_LSB_MIR];
                     end
                  end
               end
            end
         end
         default: begin
            if (commit && pwrite && paddr == `SCRR_APB_CTRL) begin
               next_s.err = 1'b1;
            end
            next_s.boot_cnt = s.boot_cnt - 24'd1;
            if (s.boot_cnt == 24'd0) begin
               next_s.st = scrr_hs_idle;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= scrr_hs_idle;
         s.cs_n <= 1'b1;
         s.oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign spi.sclk = s.sclk;
   assign spi.chip_select_n = s.cs_n;
   assign spi.sdio_host_o = s.sdo;
   assign spi.sdio_host_oe_n = s.oe_n;

endmodule : scrr_host
`default_nettype wire

// >>> scrr_wire_props.sv
`default_nettype none
module scrr_wire_props (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // serial link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdio_host_oe_n,
   input wire logic sdio_dev_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------
   // helper logic
   // ------------
   // previous sclk, for edge detection
   logic sclk_q;
   // sclk rises seen in the current frame
   logic [5:0] rises;

   // count rises while the frame is open, clear it between frames
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         rises <= 6'h00;
      end else begin
         sclk_q <= sclk;
         if (chip_select_n) begin
            rises <= 6'h00;
         end else if (sclk && !sclk_q) begin
            rises <= rises + 6'h01;
         end
      end
   end

   // ------------
   // properties
   // ------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_idle_low; chip_select_n |-> !sclk; endproperty
   a_idle_low: assert property (p_idle_low) else $error("sclk moves outside frame");
   property p_host_first; $fell(chip_select_n) |-> !sdio_host_oe_n && !sclk; endproperty
   a_host_first: assert property (p_host_first) else $error("frame opens undriven");
   property p_host_in_frame; !sdio_host_oe_n |-> !chip_select_n; endproperty
   a_host_in_frame: assert property (p_host_in_frame) else $error("host drives idle");
   property p_high2; $rose(sclk) |=> sclk ##1 !sclk; endproperty
   a_high2: assert property (p_high2) else $error("sclk high not two cycles");
   property p_low2; $fell(sclk) && !chip_select_n |=> !sclk; endproperty
   a_low2: assert property (p_low2) else $error("sclk low too short");
   property p_len; $rose(chip_select_n) |-> rises == 6'd24; endproperty
   a_len: assert property (p_len) else $error("frame not 24 bits");
   property p_dev_on; $fell(sdio_dev_oe_n) |-> !chip_select_n && rises == 6'd16; endproperty
   a_dev_on: assert property (p_dev_on) else $error("device turns on off time");
   property p_host_off;
      $rose(sdio_host_oe_n) && !chip_select_n |-> rises == 6'd16 && !sclk;
   endproperty
   a_host_off: assert property (p_host_off) else $error("host releases off time");
endmodule : scrr_wire_props
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------
   // signals and model
   // ------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, sclk_d;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, seed;
   logic lsb_first, single_instruction, soft_reset_pulse, datapath_reset_pulse;
   logic [1:0] pair_select;
   logic [23:0] frm;
   int failures, compares, soft_seen, dp_seen, soft_exp, dp_exp;
   // model of the device settings
   int m_lsb, m_asc, m_single, m_pair;

   scrr_if spi ();
   scrr_dev scrr_dev_inst (.pclk(pclk), .presetn(presetn), .spi(spi.dev),
      .lsb_first(lsb_first), .single_instruction(single_instruction),
      .pair_select(pair_select), .soft_reset_pulse(soft_reset_pulse),
      .datapath_reset_pulse(datapath_reset_pulse));
   // short boot wait keeps the run brief
   scrr_host #(.BOOT_WAIT_CYC(20)) scrr_host_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi(spi.host));
   scrr_wire_props scrr_wire_props_inst (.pclk(pclk), .presetn(presetn), .sclk(spi.sclk),
      .chip_select_n(spi.chip_select_n), .sdio_host_oe_n(spi.sdio_host_oe_n),
      .sdio_dev_oe_n(spi.sdio_dev_oe_n));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // wire monitor: bit at each sclk rise, strobes counted
   always @(posedge pclk) begin
      sclk_d <= spi.sclk;
      if (spi.sclk && !sclk_d) frm <= {frm[22:0], spi.sdio};
      if (soft_reset_pulse === 1'b1) soft_seen++;
      if (datapath_reset_pulse === 1'b1) dp_seen++;
   end

   // ------------
   // helpers
   // ------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // readback expected from the model
   function automatic logic [7:0] m_read(input logic [14:0] a);
      if (a == 15'h0) return {1'b0, m_lsb[0], m_asc[0], 2'b00, m_asc[0], m_lsb[0], 1'b0};
      if (a == 15'h1) return {m_single[0], 7'h00};
      if (a == 15'h9) return {6'h00, m_pair[1:0]};
      return 8'h00;
   endfunction : m_read

   // bit sequence on the wire in the current order
   function automatic logic [23:0] on_wire(input logic [15:0] ins, input logic [7:0] d);
      logic [23:0] f;
      f = {ins, d};
      if (m_lsb != 0) begin
         for (int i = 0; i < 16; i++) f[23 - i] = ins[i];
         for (int i = 0; i < 8; i++) f[7 - i] = d[i];
      end
      return f;
   endfunction : on_wire

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // one apb transfer; an idle edge follows so strobes never double up
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) failures++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // read and clear the sticky refusal flag
   task automatic err_chk();
      apb(1'b0, 12'h004, 32'h0);
      chk("err", 32'h1, {31'h0, q[2]});
      apb(1'b1, 12'h004, 32'h4);
      apb(1'b0, 12'h004, 32'h0);
      chk("err clear", 32'h0, {31'h0, q[2]});
   endtask : err_chk

   // one serial command; bump sends a second order while busy
   task automatic cmd(input logic rd, input logic [14:0] a, input logic [7:0] d, input logic bump);
      logic [7:0] x;
      logic [23:0] fr;
      logic sb, hl;
      int n;
      x = rd ? m_read(a) : d;
      fr = on_wire({rd, a}, x);
      n = 0;
      sb = bump;
      hl = 1'b0;
      apb(1'b1, 12'h000, {8'h00, d, rd, a});
      // one order while the frame runs, one during the boot wait
      if (bump) apb(1'b1, 12'h000, {8'h00, 8'h01, 1'b0, 15'h9});
      q = 32'h1;
      while (q[1:0] !== 2'b00 && n < 100) begin
         apb(1'b0, 12'h004, 32'h0);
         hl = q[3];
         if (bump && q[1]) begin
            apb(1'b1, 12'h000, {8'h00, 8'h01, 1'b0, 15'h9});
            bump = 1'b0;
            q = 32'h2;
         end
         n++;
      end
      if (n == 100) failures++;
      if (sb) chk("boot order sent", 32'h0, {31'h0, bump});
      chk("frame", {8'h00, fr}, {8'h00, frm});
      if (rd) begin
         apb(1'b0, 12'h008, 32'h0);
         chk("rdata", {24'h0, x}, {24'h0, q[7:0]});
      end else if (a == 15'h0 && (d[7] | d[0])) begin
         m_lsb = 0;
         m_asc = 0;
         m_single = 0;
         m_pair = 3;
         soft_exp++;
      end else if (a == 15'h0) begin
         m_lsb = d[1] | d[6];
         m_asc = d[2] | d[5];
      end else if (a == 15'h1) begin
         m_single = d[7];
         dp_exp += d[1];
      end else if (a == 15'h9) begin
         m_pair = d[1:0];
      end
      chk("lsb_first", m_lsb, lsb_first);
      chk("single", m_single, single_instruction);
      chk("pair", m_pair, pair_select);
      chk("host order", m_lsb, hl);
   endtask : cmd

   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   // watchdog cuts a hang short
   initial begin
      repeat (30000) @(posedge pclk);
      failures++;
      end_sim();
   end

   // ------------
   // main sequence
   // ------------
   initial begin
      {presetn, psel, penable, pwrite, sclk_d} = 5'h00;
      {paddr, pwdata, frm} = 68'h0;
      {failures, compares, soft_seen, dp_seen, soft_exp, dp_exp} = {6{32'h0}};
      {m_lsb, m_asc, m_single, m_pair} = {32'h0, 32'h0, 32'h0, 32'h3};
      seed = 32'he90b;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values of the global registers
      cmd(1'b1, 15'h0, 8'h00, 1'b0);
      cmd(1'b1, 15'h1, 8'h00, 1'b0);
      cmd(1'b1, 15'h9, 8'h00, 1'b0);
      apb(1'b0, 12'h010, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      // random settings, both bit orders, mirrors and reserved bits
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         cmd(1'b0, 15'h0, {1'b0, seed[0], seed[1], 2'b11, seed[2], seed[3], 1'b0}, 1'b0);
         cmd(1'b0, 15'h9, seed[15:8], 1'b0);
         cmd(1'b1, 15'h0, 8'h00, 1'b0);
         cmd(1'b1, 15'h9, 8'h00, 1'b0);
      end
      // transfer mode and datapath reset strobe
      cmd(1'b0, 15'h1, 8'h82, 1'b0);
      cmd(1'b1, 15'h1, 8'h00, 1'b0);
      cmd(1'b0, 15'h1, 8'h02, 1'b0);
      chk("dp pulses", dp_exp, dp_seen);
      // soft reset by each bit; an order during the boot wait is refused
      cmd(1'b0, 15'h0, 8'h42, 1'b0);
      cmd(1'b0, 15'h1, 8'h80, 1'b0);
      cmd(1'b0, 15'h0, 8'h80, 1'b1);
      err_chk();
      cmd(1'b0, 15'h9, 8'h01, 1'b0);
      cmd(1'b0, 15'h0, 8'h01, 1'b0);
      cmd(1'b0, 15'h0, 8'h81, 1'b0);
      cmd(1'b1, 15'h0, 8'h00, 1'b0);
      chk("soft pulses", soft_exp, soft_seen);
      // unsupported address: write refused, read gives zero
      apb(1'b1, 12'h000, {8'h00, 8'h55, 1'b0, 15'h13});
      err_chk();
      cmd(1'b1, 15'h13, 8'h00, 1'b0);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
